/* File: swrc_pkg.sv */
// How it works
// - halt gates the processor clock; the crystal oscillator keeps running.
// - in halt the timers and the four external interrupts keep their clock.
// - only an enabled interrupt or a reset ends halt; on an interrupt the core resumes after the halt.
// - stop halts both the internal clock and the crystal oscillator.
// - stop_recovery_pin low leaves stop through a reset, start at 000C.
// - stop recovery reset leaves the port mode registers untouched.
// - first 5F enables the watchdog; later ones clear its counter.
// - once enabled, no instruction can stop the watchdog.
// - the 5F opcode sets zero flag, clears sign and overflow flags.
// - missed refresh times out into a power-on delay plus 18 cycles.
// - a software enabled watchdog does not count in stop.
// - 4F or the permanent option keeps the watchdog counting in halt; otherwise halt pauses it.
// - 4F before any 5F has no effect.
// - permanent option enables watchdog at reset exit, runs in halt and stop.
// - low supply detection resets the device.
// - low noise bypasses the divide-by-two; system clock equals crystal.
// - auto latch disable option turns off every input auto latch.
// - test disable option refuses programming and factory test entry.
// - code protect blocks program reads, leaves low noise unaffected.
// - power-on delay restarts on supply good, stop recovery, timeout.
// - the watchdog counts ticks of its own free RC-rate oscillator.
package swrc_pkg;
  // opcodes seen on the execute strobe
  localparam logic [7:0] OP_NOP = 8'hFF;
  localparam logic [7:0] OP_STOP = 8'h6F;
  localparam logic [7:0] OP_HALT = 8'h7F;
  localparam logic [7:0] OP_WDT = 8'h5F;
  localparam logic [7:0] OP_WD_HALT = 8'h4F;
  // first fetch address after any reset
  localparam logic [15:0] RESET_VECTOR = 16'h000C;
  // crystal cycles appended to the power-on delay
  localparam int XTAL_RST_CYCLES = 18;
  // default clk cycles per RC oscillator tick
  localparam int RC_DIV_DEF = 16;
  // default RC ticks of the power-on delay and the watchdog period
  localparam int POR_TICKS_DEF = 64;
  localparam int WDT_TICKS_DEF = 256;
  // flags written by the refresh opcode: zero, sign, overflow
  localparam logic [2:0] WDT_FLAGS = 3'h4;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_HALT = 3'b001,
    ST_STOP = 3'b010,
    ST_POR = 3'b011,
    ST_XRST = 3'b100
  } swrc_state_e;
  typedef enum logic [1:0] {
    CAUSE_POWER = 2'b00,
    CAUSE_STOP = 2'b01,
    CAUSE_WDT = 2'b10
  } swrc_cause_e;
endpackage

/* File: swrc_top.sv */
`timescale 1ns/100ps
module swrc_top #(
  parameter int RC_DIV = swrc_pkg::RC_DIV_DEF,
  parameter int POR_TICKS = swrc_pkg::POR_TICKS_DEF,
  parameter int WDT_TICKS = swrc_pkg::WDT_TICKS_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // opcode execute strobe from the core
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  // interrupt requests, masks and global enable
  input wire logic [5:0] irq_req,
  input wire logic [5:0] irq_mask,
  input wire logic irq_global_en,
  // pins and supply detector
  input wire logic stop_recovery_pin,
  input wire logic supply_low,
  // one-time option bits
  input wire logic opt_permanent_wdt,
  input wire logic opt_low_noise,
  input wire logic opt_latch_disable,
  input wire logic opt_test_disable,
  input wire logic opt_code_protect,
  // requests for test entry and external program read
  input wire logic test_entry_req,
  input wire logic ext_read_req,
  // clock gating
  output logic cpu_clk_en,
  output logic osc_run,
  output logic periph_clk_en,
  output logic sclk_en,
  // reset outputs
  output logic core_rst,
  output logic port_cfg_rst,
  output logic [15:0] start_addr,
  output logic [1:0] reset_cause,
  // flag update toward the core
  output logic flags_wr,
  output logic [2:0] flags_zsv,
  // status and option effects
  output logic wdt_enabled,
  output logic wdt_halt_run,
  output logic auto_latch_en,
  output logic low_noise_active,
  output logic test_grant,
  output logic ext_read_grant
);
  localparam int RW = $clog2(RC_DIV + 1);
  localparam int PW = $clog2(POR_TICKS + 1);
  localparam logic [RW-1:0] RC_LAST = RW'(RC_DIV - 1);
  localparam logic [PW-1:0] POR_LAST = PW'(POR_TICKS - 1);
  localparam logic [4:0] X_LAST = 5'(swrc_pkg::XTAL_RST_CYCLES - 1);

  swrc_pkg::swrc_state_e state_reg, state_next;
  swrc_pkg::swrc_cause_e cause_reg, cause_next;
  logic [RW-1:0] rc_cnt_reg;
  logic rc_tick_reg;
  logic [PW-1:0] por_cnt_reg;
  logic [4:0] x_cnt_reg;
  logic wdt_on_reg;
  logic wdt_halt_reg;
  logic phase_reg;
  logic wake;
  logic run_op;
  logic enter_por;
  logic in_reset;
  logic in_reset_next;

  swrc_wd_if wd();

  swrc_wdog #(.TICKS(WDT_TICKS)) u_wdog (
    .clk(clk),
    .rst_b(rst_b),
    .wd(wd)
  );

  // only an interrupt that is both masked in and globally enabled wakes
  assign wake = irq_global_en && |(irq_req & irq_mask);
  // opcodes act only while the core is clocked
  assign run_op = op_valid && (state_reg == swrc_pkg::ST_RUN);
  assign in_reset = (state_reg == swrc_pkg::ST_POR) ||
                    (state_reg == swrc_pkg::ST_XRST);
  assign in_reset_next = (state_next == swrc_pkg::ST_POR) ||
                         (state_next == swrc_pkg::ST_XRST);
  assign enter_por = (state_next == swrc_pkg::ST_POR) &&
                     (state_reg != swrc_pkg::ST_POR);

  // free RC-rate tick; it keeps running in stop, unlike the crystal
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rc_cnt_reg <= '0;
      rc_tick_reg <= 1'b0;
    end else begin
      rc_tick_reg <= (rc_cnt_reg == RC_LAST);
      rc_cnt_reg <= (rc_cnt_reg == RC_LAST) ? '0 : rc_cnt_reg + RW'(1);
    end
  end

  // sequencer; supply loss then watchdog timeout override every state
  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    unique case (state_reg)
      swrc_pkg::ST_RUN: begin
        // entry assumes software flushed the pipeline with a no-op
        if (run_op && op_code == swrc_pkg::OP_STOP) begin
          state_next = swrc_pkg::ST_STOP;
        end else if (run_op && op_code == swrc_pkg::OP_HALT) begin
          state_next = swrc_pkg::ST_HALT;
        end
      end
      swrc_pkg::ST_HALT: begin
        if (wake) begin
          state_next = swrc_pkg::ST_RUN;
        end
      end
      swrc_pkg::ST_STOP: begin
        // pin is read even when the port drives it as an output
        if (!stop_recovery_pin) begin
          state_next = swrc_pkg::ST_POR;
          cause_next = swrc_pkg::CAUSE_STOP;
        end
      end
      swrc_pkg::ST_POR: begin
        if (rc_tick_reg && por_cnt_reg == POR_LAST) begin
          state_next = swrc_pkg::ST_XRST;
        end
      end
      swrc_pkg::ST_XRST: begin
        if (x_cnt_reg == X_LAST) begin
          state_next = swrc_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = swrc_pkg::ST_POR;
        cause_next = swrc_pkg::CAUSE_POWER;
      end
    endcase
    if (wd.timeout) begin
      state_next = swrc_pkg::ST_POR;
      cause_next = swrc_pkg::CAUSE_WDT;
    end
    if (supply_low) begin
      state_next = swrc_pkg::ST_POR;
      cause_next = swrc_pkg::CAUSE_POWER;
    end
  end

  // state and cause of the last reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= swrc_pkg::ST_POR;
      cause_reg <= swrc_pkg::CAUSE_POWER;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
    end
  end

  // one-shot power-on delay, restarted on entry and while supply is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_cnt_reg <= '0;
    end else if (enter_por || supply_low) begin
      por_cnt_reg <= '0;
    end else if (state_reg == swrc_pkg::ST_POR && rc_tick_reg) begin
      por_cnt_reg <= por_cnt_reg + PW'(1);
    end
  end

  // crystal cycles appended after the delay
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      x_cnt_reg <= '0;
    end else if (state_reg == swrc_pkg::ST_XRST &&
                 state_next == swrc_pkg::ST_XRST) begin
      x_cnt_reg <= x_cnt_reg + 5'h01;
    end else begin
      x_cnt_reg <= '0;
    end
  end

  // watchdog enable: only a reset drops it; when permanent, reset exit sets it again
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_on_reg <= 1'b0;
    end else if (enter_por) begin
      wdt_on_reg <= 1'b0;
    end else if (state_reg == swrc_pkg::ST_XRST &&
                 state_next == swrc_pkg::ST_RUN && opt_permanent_wdt) begin
      wdt_on_reg <= 1'b1;
    end else if (run_op && op_code == swrc_pkg::OP_WDT) begin
      wdt_on_reg <= 1'b1;
    end
  end

  // run-in-halt permission; ignored until the watchdog is on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_halt_reg <= 1'b0;
    end else if (enter_por) begin
      wdt_halt_reg <= 1'b0;
    end else if (run_op && op_code == swrc_pkg::OP_WD_HALT && wdt_on_reg) begin
      wdt_halt_reg <= 1'b1;
    end
  end

  // watchdog gating per mode; counter holds whenever this and clear are both low
  assign wd.tick = rc_tick_reg;
  assign wd.count_en = wdt_on_reg &&
    (state_reg == swrc_pkg::ST_RUN ||
     (state_reg == swrc_pkg::ST_HALT &&
      (wdt_halt_reg || opt_permanent_wdt)) ||
     (state_reg == swrc_pkg::ST_STOP && opt_permanent_wdt));
  assign wd.clear = in_reset ||
    (run_op && op_code == swrc_pkg::OP_WDT && wdt_on_reg);

  // clock gating outputs, registered from the next state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_clk_en <= 1'b0;
      osc_run <= 1'b1;
      periph_clk_en <= 1'b0;
    end else begin
      cpu_clk_en <= (state_next == swrc_pkg::ST_RUN);
      osc_run <= (state_next != swrc_pkg::ST_STOP);
      periph_clk_en <= (state_next == swrc_pkg::ST_RUN) ||
                       (state_next == swrc_pkg::ST_HALT);
    end
  end

  // system clock enable, off in stop: every cycle in low noise, else every other one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= 1'b0;
      sclk_en <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      sclk_en <= (state_next != swrc_pkg::ST_STOP) &&
                 (opt_low_noise || phase_reg);
    end
  end

  // reset outputs; port modes survive a stop recovery
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_rst <= 1'b1;
      port_cfg_rst <= 1'b1;
      start_addr <= swrc_pkg::RESET_VECTOR;
      reset_cause <= swrc_pkg::CAUSE_POWER;
    end else begin
      core_rst <= in_reset_next;
      port_cfg_rst <= in_reset_next &&
                      cause_next != swrc_pkg::CAUSE_STOP;
      start_addr <= swrc_pkg::RESET_VECTOR;
      reset_cause <= cause_next;
    end
  end

  // flag write pulse for the refresh opcode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_wr <= 1'b0;
      flags_zsv <= '0;
    end else begin
      flags_wr <= run_op && op_code == swrc_pkg::OP_WDT;
      flags_zsv <= swrc_pkg::WDT_FLAGS;
    end
  end

  // option effects and status; code protect does not touch low noise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_enabled <= 1'b0;
      wdt_halt_run <= 1'b0;
      auto_latch_en <= 1'b0;
      low_noise_active <= 1'b0;
      test_grant <= 1'b0;
      ext_read_grant <= 1'b0;
    end else begin
      wdt_enabled <= wdt_on_reg;
      wdt_halt_run <= wdt_halt_reg;
      auto_latch_en <= !opt_latch_disable;
      low_noise_active <= opt_low_noise;
      test_grant <= test_entry_req && !opt_test_disable;
      ext_read_grant <= ext_read_req && !opt_code_protect;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  halt_gate_a: assert property (
    state_reg == swrc_pkg::ST_HALT |-> !cpu_clk_en && osc_run)
    else $error("halt did not gate cpu clock only");
  halt_periph_a: assert property (
    state_reg == swrc_pkg::ST_HALT |-> periph_clk_en)
    else $error("peripherals stopped in halt");
  halt_wake_a: assert property (
    state_reg == swrc_pkg::ST_HALT && wake && !supply_low && !wd.timeout
    |=> state_reg == swrc_pkg::ST_RUN && cpu_clk_en)
    else $error("enabled interrupt did not end halt");
  stop_osc_a: assert property (
    state_reg == swrc_pkg::ST_STOP |-> !osc_run && !cpu_clk_en)
    else $error("oscillator running in stop");
  stop_release_a: assert property (
    state_reg == swrc_pkg::ST_STOP && !stop_recovery_pin
    |=> core_rst && state_reg == swrc_pkg::ST_POR)
    else $error("recovery pin did not reset out of stop");
  port_keep_a: assert property (
    state_reg == swrc_pkg::ST_STOP && !stop_recovery_pin && !supply_low
    && !wd.timeout |=> !port_cfg_rst)
    else $error("port modes reset on stop recovery");
  wdt_sticky_a: assert property (
    wdt_on_reg && !in_reset_next |=> wdt_on_reg)
    else $error("watchdog disabled without reset");
  wdt_flags_a: assert property (
    run_op && op_code == swrc_pkg::OP_WDT
    |=> flags_wr && flags_zsv == 3'h4)
    else $error("refresh opcode flags wrong");
  halt_run_ignore_a: assert property (
    run_op && op_code == swrc_pkg::OP_WD_HALT && !wdt_on_reg
    && !wdt_halt_reg |=> !wdt_halt_reg)
    else $error("run-in-halt set before watchdog enable");
  low_supply_a: assert property (
    supply_low |=> core_rst && port_cfg_rst ##1 core_rst)
    else $error("low supply did not reset");
  xtal_tail_a: assert property (
    $rose(state_reg == swrc_pkg::ST_XRST) && !supply_low
    |-> ##17 (state_reg == swrc_pkg::ST_XRST || supply_low || wd.timeout))
    else $error("crystal tail shorter than expected");
  test_block_a: assert property (
    opt_test_disable |=> !test_grant)
    else $error("test entry granted while disabled");
endmodule

/* File: swrc_wd_if.sv */
`timescale 1ns/100ps
interface swrc_wd_if;
  logic tick;
  logic count_en;
  logic clear;
  logic timeout;
  modport ctl(output tick, output count_en, output clear, input timeout);
  modport cnt(input tick, input count_en, input clear, output timeout);
endinterface

/* File: swrc_wdog.sv */
`timescale 1ns/100ps
module swrc_wdog #(
  parameter int TICKS = swrc_pkg::WDT_TICKS_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control from the sleep and reset sequencer
  swrc_wd_if.cnt wd
);
  localparam int W = $clog2(TICKS + 1);
  localparam logic [W-1:0] LAST = W'(TICKS - 1);
  logic [W-1:0] cnt_reg;
  logic timeout_reg;
  logic hit;

  // terminal tick; a refresh in the same cycle wins over the timeout
  assign hit = wd.count_en && wd.tick && (cnt_reg == LAST) && !wd.clear;
  assign wd.timeout = timeout_reg;

  // count only on RC ticks while enabled, zero on clear or terminal tick, otherwise hold the value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else if (wd.clear || hit) begin
      cnt_reg <= '0;
    end else if (wd.count_en && wd.tick) begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

  // one-cycle timeout pulse toward the sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= hit;
    end
  end

  count_hold_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !wd.count_en && !wd.clear |=> cnt_reg == $past(cnt_reg))
    else $error("watchdog count moved while paused");

  timeout_term_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    timeout_reg |-> $past(cnt_reg) == LAST && $past(wd.tick)
                    && cnt_reg == '0)
    else $error("watchdog timeout without terminal count");
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  localparam int RC_DIV = 4;
  localparam int POR_TICKS = 4;
  localparam int WDT_TICKS = 8;
  localparam int WD_CYC = WDT_TICKS * RC_DIV;
  localparam int POR_CYC = RC_DIV * POR_TICKS + swrc_pkg::XTAL_RST_CYCLES;
  // stimulus, all given a value at time zero
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic op_valid = 1'b0;
  logic [7:0] op_code = 8'hFF;
  logic [5:0] irq_req = 6'h00;
  logic [5:0] irq_mask = 6'h00;
  logic irq_global_en = 1'b0;
  logic stop_recovery_pin = 1'b1;
  logic supply_low = 1'b0;
  logic opt_permanent_wdt = 1'b0;
  logic opt_low_noise = 1'b0;
  logic opt_latch_disable = 1'b0;
  logic opt_test_disable = 1'b0;
  logic opt_code_protect = 1'b0;
  logic test_entry_req = 1'b0;
  logic ext_read_req = 1'b0;
  // observed outputs
  logic cpu_clk_en, osc_run, periph_clk_en, sclk_en, core_rst, port_cfg_rst;
  logic [15:0] start_addr;
  logic [1:0] reset_cause;
  logic flags_wr, wdt_enabled, wdt_halt_run, auto_latch_en;
  logic [2:0] flags_zsv;
  logic low_noise_active, test_grant, ext_read_grant;
  // bookkeeping
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 92374;
  logic [31:0] r;
  logic s;
  logic [2:0] flag_q[$];

  swrc_top #(.RC_DIV(RC_DIV), .POR_TICKS(POR_TICKS), .WDT_TICKS(WDT_TICKS))
  u_dut (.clk, .rst_b, .op_valid, .op_code, .irq_req, .irq_mask,
    .irq_global_en, .stop_recovery_pin, .supply_low, .opt_permanent_wdt,
    .opt_low_noise, .opt_latch_disable, .opt_test_disable, .opt_code_protect,
    .test_entry_req, .ext_read_req, .cpu_clk_en, .osc_run, .periph_clk_en,
    .sclk_en, .core_rst, .port_cfg_rst, .start_addr, .reset_cause, .flags_wr,
    .flags_zsv, .wdt_enabled, .wdt_halt_run, .auto_latch_en,
    .low_noise_active, .test_grant, .ext_read_grant);

  always #25 clk = ~clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard at 10000 cycles; the whole run needs under a thousand
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      failures++;
      results();
    end
  end

  // result watcher: every flag write takes the oldest note off the queue
  always @(negedge clk) begin
    if (flags_wr === 1'b1) begin
      if (flag_q.size() == 0) begin
        chk(16'h1, 16'h0);
      end else begin
        chk({13'h0, flags_zsv}, {13'h0, flag_q.pop_front()});
      end
    end
  end

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one executed opcode; a refresh taken in run notes its flag write
  task automatic op(input logic [7:0] code);
    @(negedge clk);
    if (code == swrc_pkg::OP_WDT && cpu_clk_en === 1'b1) begin
      flag_q.push_back(3'h4);
    end
    op_valid = 1'b1;
    op_code = code;
    @(negedge clk);
    op_valid = 1'b0;
  endtask

  // reset delay length is checked loosely since the rc tick phase varies
  task automatic wait_run;
    int n;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(n >= POR_CYC - RC_DIV - 4 && n <= POR_CYC + RC_DIV + 4, 1);
    chk(core_rst, 0);
  endtask

  task automatic wait_rst(input int lim);
    int n;
    n = 0;
    while (core_rst !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(n < lim, 1);
  endtask

  task automatic wake;
    r = $random(seed);
    irq_req = 6'h01 << (r[7:0] % 6);
    irq_mask = ~irq_req;
    irq_global_en = 1'b1;
    cycles(4);
    chk(cpu_clk_en, 0);
    irq_mask = irq_req;
    irq_global_en = 1'b0;
    cycles(4);
    chk(cpu_clk_en, 0);
    irq_global_en = 1'b1;
    cycles(2);
    chk(cpu_clk_en, 1);
    irq_req = 6'h00;
  endtask

  initial begin
    // power-on reset and first exit
    cycles(12);
    chk(core_rst, 1);
    chk(port_cfg_rst, 1);
    chk(osc_run, 1);
    chk(cpu_clk_en, 0);
    rst_b = 1'b1;
    wait_run();
    chk(start_addr, 16'h000C);
    chk(reset_cause, 0);
    chk(wdt_enabled, 0);
    $display("test reset done");
    // option bits as live levels
    repeat (8) begin
      r = $random(seed);
      {opt_low_noise, opt_latch_disable, opt_test_disable} = r[2:0];
      {opt_code_protect, test_entry_req, ext_read_req} = r[5:3];
      cycles(2);
      chk(auto_latch_en, !opt_latch_disable);
      chk(low_noise_active, opt_low_noise);
      chk(test_grant, test_entry_req & !opt_test_disable);
      chk(ext_read_grant, ext_read_req & !opt_code_protect);
      s = sclk_en;
      cycles(1);
      chk(sclk_en, opt_low_noise ? 1'b1 : !s);
    end
    {opt_low_noise, opt_latch_disable, opt_test_disable} = 3'h0;
    {opt_code_protect, test_entry_req, ext_read_req} = 3'h0;
    $display("test options done");
    // halt before any watchdog enable
    op(swrc_pkg::OP_WD_HALT);
    cycles(1);
    chk(wdt_halt_run, 0);
    op(swrc_pkg::OP_NOP);
    op(swrc_pkg::OP_HALT);
    cycles(1);
    chk(cpu_clk_en, 0);
    chk(osc_run, 1);
    chk(periph_clk_en, 1);
    wake();
    $display("test halt done");
    // refresh keeps the watchdog quiet across several periods
    op(swrc_pkg::OP_WDT);
    cycles(1);
    chk(wdt_enabled, 1);
    repeat (6) begin
      cycles(WD_CYC / 2);
      op(swrc_pkg::OP_WDT);
    end
    chk(core_rst, 0);
    // paused in halt, count held and resumed after wake
    cycles(20);
    op(swrc_pkg::OP_NOP);
    op(swrc_pkg::OP_HALT);
    cycles(WD_CYC * 3);
    chk(core_rst, 0);
    wake();
    wait_rst(24);
    chk(reset_cause, 2);
    chk(port_cfg_rst, 1);
    wait_run();
    chk(wdt_enabled, 0);
    // run-in-halt permission lets the watchdog expire in halt
    op(swrc_pkg::OP_WDT);
    op(swrc_pkg::OP_WD_HALT);
    cycles(1);
    chk(wdt_halt_run, 1);
    op(swrc_pkg::OP_NOP);
    op(swrc_pkg::OP_HALT);
    wait_rst(WD_CYC + 12);
    chk(reset_cause, 2);
    wait_run();
    $display("test watchdog done");
    // stop mode: no software watchdog count, recovery keeps port modes
    op(swrc_pkg::OP_WDT);
    op(swrc_pkg::OP_NOP);
    op(swrc_pkg::OP_STOP);
    cycles(1);
    chk(osc_run, 0);
    chk(cpu_clk_en, 0);
    chk(sclk_en, 0);
    cycles(WD_CYC * 2);
    chk(core_rst, 0);
    stop_recovery_pin = 1'b0;
    cycles(2);
    chk(core_rst, 1);
    chk(osc_run, 1);
    chk(port_cfg_rst, 0);
    chk(reset_cause, 1);
    stop_recovery_pin = 1'b1;
    wait_run();
    chk(start_addr, 16'h000C);
    $display("test stop done");
    // permanent watchdog, entered through a mid-run reset
    opt_permanent_wdt = 1'b1;
    rst_b = 1'b0;
    cycles(2);
    rst_b = 1'b1;
    wait_run();
    // status output trails the internal enable by one cycle
    cycles(1);
    chk(wdt_enabled, 1);
    op(swrc_pkg::OP_NOP);
    op(swrc_pkg::OP_STOP);
    wait_rst(WD_CYC + 12);
    chk(reset_cause, 2);
    wait_run();
    opt_permanent_wdt = 1'b0;
    $display("test permanent done");
    // low supply holds the device in reset
    supply_low = 1'b1;
    cycles(2);
    chk(core_rst, 1);
    chk(port_cfg_rst, 1);
    chk(reset_cause, 0);
    cycles(POR_CYC * 2);
    chk(core_rst, 1);
    supply_low = 1'b0;
    wait_run();
    chk(wdt_enabled, 0);
    $display("test supply done");
    // every noted refresh must have produced its flag write
    chk(16'(flag_q.size()), 16'h0);
    results();
  end
endmodule
